// *** core/usbf_defines.svh ***
`ifndef USBF_DEFINES_SVH
`define USBF_DEFINES_SVH

// ****************************************
// Indirect register addresses
// ****************************************
`define USBF_ADR_FUNCTION_ADDRESS      8'h00
`define USBF_ADR_POWER      8'h01
`define USBF_ADR_IN_INT     8'h02
`define USBF_ADR_OUT_INT    8'h04
`define USBF_ADR_CM_INT     8'h06
`define USBF_ADR_IN_IE      8'h07
`define USBF_ADR_OUT_IE     8'h09
`define USBF_ADR_CM_IE      8'h0B
`define USBF_ADR_FRAME_L    8'h0C
`define USBF_ADR_FRAME_H    8'h0D
`define USBF_ADR_INDEX      8'h0E
`define USBF_ADR_CLOCK_RECOVERY_CONTROL     8'h0F
`define USBF_ADR_CTRL_L     8'h11
`define USBF_ADR_IN_CTRL_H  8'h12
`define USBF_ADR_OUT_CTRL_L 8'h14
`define USBF_ADR_OUT_CTRL_H 8'h15
`define USBF_ADR_CNT_L      8'h16
`define USBF_ADR_CNT_H      8'h17
`define USBF_ADR_EP_EN      8'h1E
`define USBF_ADR_FIFO0      8'h20
`define USBF_ADR_FIFO3      8'h23

// ****************************************
// Reset values
// ****************************************
`define USBF_RST_POWER      8'h10
`define USBF_RST_IN_IE      8'h0F
`define USBF_RST_OUT_IE     8'h0E
`define USBF_RST_CM_IE      8'h06
`define USBF_RST_EP_EN      8'h0F

// ****************************************
// Field positions
// ****************************************
`define USBF_INH_DBL        7
`define USBF_INH_ENDPOINT_DIRECTION_SELECT     5
`define USBF_INH_SPLIT      2
`define USBF_OUTH_DBL       7
`define USBF_CLOCK_RECOVERY_CONTROL_EN      7
`define USBF_CLOCK_RECOVERY_CONTROL_LOW     5

// ****************************************
// Endpoint FIFO regions in the 1024-byte memory
// ****************************************
`define USBF_MEM_BYTES      1024
`define USBF_EP0_BASE       10'h000
`define USBF_EP1_BASE       10'h040
`define USBF_EP2_BASE       10'h0C0
`define USBF_EP3_BASE       10'h1C0
`define USBF_EP0_SIZE       10'h040
`define USBF_EP1_SIZE       10'h080
`define USBF_EP2_SIZE       10'h100
`define USBF_EP3_SIZE       10'h200
`define USBF_RX_FIFO_DEPTH  8

`endif

// *** core/usbf_pkg.sv ***
package usbf_pkg;

  // Transceiver control register layout
  typedef struct packed {
    logic       pullup_en;
    logic       xcvr_en;
    logic       speed;
    logic [1:0] phy_test_select;
    logic [2:0] rsvd;
  } usbf_xcvr_t;

  // Interrupt flag set strobes from the serial engine
  typedef struct packed {
    logic [7:0] in_set;
    logic [7:0] out_set;
    logic [7:0] cm_set;
  } usbf_evt_t;

  // Received byte with its endpoint
  typedef struct packed {
    logic [1:0] ep;
    logic [7:0] data;
  } usbf_rx_t;

endpackage : usbf_pkg

// *** core/usbf_top.sv ***

`include "usbf_defines.svh"

// ****************************************
// Receive FIFO
// ****************************************
module usbf_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = `USBF_RX_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  // Fill side
  input  wire logic             i_valid,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_ready,
  // Drain side
  output logic                  o_valid,
  output logic      [WIDTH-1:0] o_data,
  input  wire logic             i_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr_q;
  logic [AW-1:0]    rptr_q;
  logic [AW:0]      cnt_q;
  logic             ready_q;
  logic             push;
  logic             pop;
  logic [AW:0]      cnt_d;

  assign o_valid = (cnt_q != '0);
  assign o_data  = mem[rptr_q];
  assign o_ready = ready_q;
  assign push    = i_valid && ready_q;
  assign pop     = o_valid && i_ready;

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wptr_q] <= i_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wptr_q  <= '0;
      rptr_q  <= '0;
      cnt_q   <= '0;
      ready_q <= 1'b0;
    end else begin
      wptr_q  <= push ? AW'(wptr_q + 1'b1) : wptr_q;
      rptr_q  <= pop ? AW'(rptr_q + 1'b1) : rptr_q;
      cnt_q   <= cnt_d;
      ready_q <= (cnt_d != (AW+1)'(DEPTH));
    end
  end
endmodule // usbf_fifo

// ****************************************
// Endpoint, transceiver and FIFO control
// ****************************************
module usbf_top #(
  parameter int RX_DEPTH = `USBF_RX_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_rst_n,
  // Indirect address and data ports
  input  wire logic                i_adr_wr,
  input  wire logic [7:0]          i_adr_wdata,
  input  wire logic                i_dat_wr,
  input  wire logic                i_dat_rd,
  input  wire logic [7:0]          i_dat_wdata,
  output logic      [7:0]          o_dat_rdata,
  output logic                     o_dat_rvalid,
  // Transceiver control register
  input  wire logic                i_xcvr_wr,
  input  wire usbf_pkg::usbf_xcvr_t i_xcvr_wdata,
  output usbf_pkg::usbf_xcvr_t     o_xcvr_ctrl,
  output logic                     o_xcvr_en,
  output logic                     o_full_speed,
  output logic                     o_pullup_dp,
  output logic                     o_pullup_dm,
  // USB clock selection and recovery
  input  wire logic                i_clk_sel_wr,
  input  wire logic [2:0]          i_clk_src,
  input  wire logic                i_clk_src_en,
  output logic                     o_usb_clk_en,
  output logic      [2:0]          o_usb_clk_src,
  output logic                     o_clock_recovery_control_trim_en,
  // VBUS pin and reset source
  input  wire logic                i_vbus,
  input  wire logic                i_vbus_rise_ie,
  input  wire logic                i_vbus_fall_ie,
  input  wire logic                i_usb_rst_src_en,
  output logic                     o_bus_power_level,
  output logic                     o_vbus_irq,
  output logic                     o_sys_rst_req,
  // Serial engine status
  input  wire usbf_pkg::usbf_evt_t i_sie_evt,
  input  wire logic [10:0]         i_frame_num,
  output logic      [6:0]          o_function_address,
  output logic      [7:0]          o_power,
  output logic      [7:0]          o_ep_enable,
  output logic      [9:0]          o_max_in_pkt,
  output logic      [9:0]          o_max_out_pkt,
  // Serial engine receive stream
  input  wire logic                i_rx_valid,
  input  wire usbf_pkg::usbf_rx_t  i_rx_data,
  output logic                     o_rx_ready,
  // Serial engine transmit fetch
  input  wire logic                i_tx_req,
  input  wire logic [1:0]          i_tx_ep,
  output logic                     o_tx_valid,
  output logic      [7:0]          o_tx_data
);
  // ****************************************
  // Declarations
  // ****************************************
  logic [7:0] mem [`USBF_MEM_BYTES];
  logic [9:0] wptr_q [8];
  logic [9:0] rptr_q [8];
  logic [9:0] cnt_q  [8];
  logic [9:0] pbase  [8];
  logic [9:0] psize  [8];
  logic [7:0] ctrl_l_q [4];
  logic [7:0] in_h_q   [4];
  logic [7:0] out_l_q  [4];
  logic [7:0] out_h_q  [4];
  logic [7:0] adr_q, index_q, power_q, ep_en_q, clock_recovery_control_q;
  logic [6:0] function_address_q;
  logic [7:0] in_flag_q, out_flag_q, cm_flag_q, in_ie_q, out_ie_q, cm_ie_q;
  logic [3:0] split;
  logic       vbus_s1_q, vbus_s2_q, vbus_s3_q;
  logic [1:0] idx;
  logic       idx_ok, idx_ep;
  logic [7:0] rd_mux;
  logic       is_fifo;
  logic [1:0] ep_c;
  logic [2:0] pop_pipe, push_pipe, rx_pipe, tx_pipe;
  logic       core_rd_fifo, core_wr_fifo, rx_ok, rx_push, tx_pop;
  logic       f_valid, f_ready;
  usbf_pkg::usbf_rx_t f_data;

  function automatic logic in_allowed(input logic [1:0] ep, input logic sp,
                                      input logic dir);
    return (ep == 2'd0) || sp || dir;
  endfunction

  function automatic logic out_allowed(input logic [1:0] ep, input logic sp,
                                       input logic dir);
    return (ep == 2'd0) || sp || !dir;
  endfunction

  // ****************************************
  // FIFO regions and pipe mapping
  // ****************************************
  always_comb begin
    for (int e = 0; e < 4; e++) begin
      split[e] = (e != 0) && in_h_q[e][`USBF_INH_SPLIT];
    end
  end

  // Pipes 0-3 are endpoint buffers (OUT or shared), 5-7 are split IN halves; pipe 4 is unused
  always_comb begin
    logic [9:0] b, s;
    b = '0;
    s = '0;
    for (int p = 0; p < 8; p++) begin
      case (p % 4)
        0: begin b = `USBF_EP0_BASE; s = `USBF_EP0_SIZE; end
        1: begin b = `USBF_EP1_BASE; s = `USBF_EP1_SIZE; end
        2: begin b = `USBF_EP2_BASE; s = `USBF_EP2_SIZE; end
        default: begin b = `USBF_EP3_BASE; s = `USBF_EP3_SIZE; end
      endcase
      if (split[p % 4]) begin
        psize[p] = s >> 1;
        pbase[p] = (p >= 4) ? 10'(b + (s >> 1)) : b;
      end else begin
        psize[p] = s;
        pbase[p] = b;
      end
    end
  end

  // ****************************************
  // Core FIFO port and serial engine paths
  // ****************************************
  assign is_fifo   = (adr_q >= `USBF_ADR_FIFO0) && (adr_q <= `USBF_ADR_FIFO3);
  assign ep_c      = adr_q[1:0];
  assign pop_pipe  = {1'b0, ep_c};
  assign push_pipe = {split[ep_c], ep_c};
  assign rx_pipe   = {1'b0, f_data.ep};
  assign tx_pipe   = {split[i_tx_ep], i_tx_ep};

  assign core_rd_fifo = i_dat_rd && is_fifo && (cnt_q[pop_pipe] != '0) &&
                        out_allowed(ep_c, split[ep_c], in_h_q[ep_c][`USBF_INH_ENDPOINT_DIRECTION_SELECT]);
  assign core_wr_fifo = i_dat_wr && is_fifo && (cnt_q[push_pipe] != psize[push_pipe]) &&
                        in_allowed(ep_c, split[ep_c], in_h_q[ep_c][`USBF_INH_ENDPOINT_DIRECTION_SELECT]);

  // Bytes for an endpoint set to IN are drained and dropped
  assign rx_ok   = out_allowed(f_data.ep, split[f_data.ep],
                               in_h_q[f_data.ep][`USBF_INH_ENDPOINT_DIRECTION_SELECT]);
  assign f_ready = !core_wr_fifo && (!rx_ok || (cnt_q[rx_pipe] != psize[rx_pipe]));
  assign rx_push = f_valid && f_ready && rx_ok;
  assign tx_pop  = i_tx_req && (cnt_q[tx_pipe] != '0) &&
                   in_allowed(i_tx_ep, split[i_tx_ep], in_h_q[i_tx_ep][`USBF_INH_ENDPOINT_DIRECTION_SELECT]) &&
                   !(core_rd_fifo && (pop_pipe == tx_pipe));

  usbf_fifo #(
    .WIDTH ($bits(usbf_pkg::usbf_rx_t)),
    .DEPTH (RX_DEPTH)
  ) u_rx_fifo (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_valid (i_rx_valid),
    .i_data  (i_rx_data),
    .o_ready (o_rx_ready),
    .o_valid (f_valid),
    .o_data  (f_data),
    .i_ready (f_ready)
  );

  // Single write port: a core write stalls the receive drain
  always_ff @(posedge i_clk) begin
    if (core_wr_fifo) begin
      mem[10'(pbase[push_pipe] + wptr_q[push_pipe])] <= i_dat_wdata;
    end else if (rx_push) begin
      mem[10'(pbase[rx_pipe] + wptr_q[rx_pipe])] <= f_data.data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int p = 0; p < 8; p++) begin
        wptr_q[p] <= '0;
        rptr_q[p] <= '0;
        cnt_q[p]  <= '0;
      end
    end else begin
      for (int p = 0; p < 8; p++) begin
        logic push, pop;
        push = (core_wr_fifo && (push_pipe == 3'(p))) || (rx_push && (rx_pipe == 3'(p)));
        pop  = (core_rd_fifo && (pop_pipe == 3'(p))) || (tx_pop && (tx_pipe == 3'(p)));
        if (push) begin
          wptr_q[p] <= (10'(wptr_q[p] + 1'b1) == psize[p]) ? '0 : 10'(wptr_q[p] + 1'b1);
        end
        if (pop) begin
          rptr_q[p] <= (10'(rptr_q[p] + 1'b1) == psize[p]) ? '0 : 10'(rptr_q[p] + 1'b1);
        end
        if (push && !pop) begin
          cnt_q[p] <= 10'(cnt_q[p] + 1'b1);
        end else if (pop && !push) begin
          cnt_q[p] <= 10'(cnt_q[p] - 1'b1);
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tx_valid <= 1'b0;
      o_tx_data  <= '0;
    end else begin
      o_tx_valid <= tx_pop;
      o_tx_data  <= tx_pop ? mem[10'(pbase[tx_pipe] + rptr_q[tx_pipe])] : 8'h00;
    end
  end

  // ****************************************
  // Indirect register access
  // ****************************************
  assign idx    = index_q[1:0];
  assign idx_ok = (index_q < 8'h04);
  assign idx_ep = idx_ok && (idx != 2'd0);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      adr_q <= '0;
    end else if (i_adr_wr) begin
      adr_q <= i_adr_wdata;
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    if (adr_q == `USBF_ADR_FUNCTION_ADDRESS) begin
      rd_mux = {1'b0, function_address_q};
    end else if (adr_q == `USBF_ADR_POWER) begin
      rd_mux = power_q;
    end else if (adr_q == `USBF_ADR_IN_INT) begin
      rd_mux = in_flag_q;
    end else if (adr_q == `USBF_ADR_OUT_INT) begin
      rd_mux = out_flag_q;
    end else if (adr_q == `USBF_ADR_CM_INT) begin
      rd_mux = cm_flag_q;
    end else if (adr_q == `USBF_ADR_IN_IE) begin
      rd_mux = in_ie_q;
    end else if (adr_q == `USBF_ADR_OUT_IE) begin
      rd_mux = out_ie_q;
    end else if (adr_q == `USBF_ADR_CM_IE) begin
      rd_mux = cm_ie_q;
    end else if (adr_q == `USBF_ADR_FRAME_L) begin
      rd_mux = i_frame_num[7:0];
    end else if (adr_q == `USBF_ADR_FRAME_H) begin
      rd_mux = {5'h00, i_frame_num[10:8]};
    end else if (adr_q == `USBF_ADR_INDEX) begin
      rd_mux = index_q;
    end else if (adr_q == `USBF_ADR_CLOCK_RECOVERY_CONTROL) begin
      rd_mux = clock_recovery_control_q;
    end else if (adr_q == `USBF_ADR_EP_EN) begin
      rd_mux = ep_en_q;
    end else if (idx_ok && (adr_q == `USBF_ADR_CTRL_L)) begin
      rd_mux = ctrl_l_q[idx];
    end else if (idx_ep && (adr_q == `USBF_ADR_IN_CTRL_H)) begin
      rd_mux = in_h_q[idx];
    end else if (idx_ep && (adr_q == `USBF_ADR_OUT_CTRL_L)) begin
      rd_mux = out_l_q[idx];
    end else if (idx_ep && (adr_q == `USBF_ADR_OUT_CTRL_H)) begin
      rd_mux = out_h_q[idx];
    end else if (idx_ok && (adr_q == `USBF_ADR_CNT_L)) begin
      rd_mux = cnt_q[{1'b0, idx}][7:0];
    end else if (idx_ep && (adr_q == `USBF_ADR_CNT_H)) begin
      rd_mux = {6'h00, cnt_q[{1'b0, idx}][9:8]};
    end else if (is_fifo && core_rd_fifo) begin
      rd_mux = mem[10'(pbase[pop_pipe] + rptr_q[pop_pipe])];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_dat_rdata  <= '0;
      o_dat_rvalid <= 1'b0;
    end else begin
      o_dat_rvalid <= i_dat_rd;
      o_dat_rdata  <= i_dat_rd ? rd_mux : 8'h00;
    end
  end

  // Set wins over the read clear
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      in_flag_q  <= '0;
      out_flag_q <= '0;
      cm_flag_q  <= '0;
    end else begin
      in_flag_q  <= (in_flag_q & ~{8{i_dat_rd && (adr_q == `USBF_ADR_IN_INT)}}) |
                    i_sie_evt.in_set;
      out_flag_q <= (out_flag_q & ~{8{i_dat_rd && (adr_q == `USBF_ADR_OUT_INT)}}) |
                    i_sie_evt.out_set;
      cm_flag_q  <= (cm_flag_q & ~{8{i_dat_rd && (adr_q == `USBF_ADR_CM_INT)}}) |
                    i_sie_evt.cm_set;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      function_address_q  <= '0;
      power_q  <= `USBF_RST_POWER;
      in_ie_q  <= `USBF_RST_IN_IE;
      out_ie_q <= `USBF_RST_OUT_IE;
      cm_ie_q  <= `USBF_RST_CM_IE;
      index_q  <= '0;
      clock_recovery_control_q <= '0;
      ep_en_q  <= `USBF_RST_EP_EN;
    end else if (i_dat_wr) begin
      if (adr_q == `USBF_ADR_FUNCTION_ADDRESS) begin
        function_address_q <= i_dat_wdata[6:0];
      end else if (adr_q == `USBF_ADR_POWER) begin
        power_q <= i_dat_wdata;
      end else if (adr_q == `USBF_ADR_IN_IE) begin
        in_ie_q <= i_dat_wdata;
      end else if (adr_q == `USBF_ADR_OUT_IE) begin
        out_ie_q <= i_dat_wdata;
      end else if (adr_q == `USBF_ADR_CM_IE) begin
        cm_ie_q <= i_dat_wdata;
      end else if (adr_q == `USBF_ADR_INDEX) begin
        index_q <= i_dat_wdata;
      end else if (adr_q == `USBF_ADR_CLOCK_RECOVERY_CONTROL) begin
        clock_recovery_control_q <= i_dat_wdata;
      end else if (adr_q == `USBF_ADR_EP_EN) begin
        ep_en_q <= i_dat_wdata;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int e = 0; e < 4; e++) begin
        ctrl_l_q[e] <= '0;
        in_h_q[e]   <= '0;
        out_l_q[e]  <= '0;
        out_h_q[e]  <= '0;
      end
    end else if (i_dat_wr && idx_ok) begin
      if (adr_q == `USBF_ADR_CTRL_L) begin
        ctrl_l_q[idx] <= i_dat_wdata;
      end else if (idx_ep && (adr_q == `USBF_ADR_IN_CTRL_H)) begin
        in_h_q[idx] <= i_dat_wdata;
      end else if (idx_ep && (adr_q == `USBF_ADR_OUT_CTRL_L)) begin
        out_l_q[idx] <= i_dat_wdata;
      end else if (idx_ep && (adr_q == `USBF_ADR_OUT_CTRL_H)) begin
        out_h_q[idx] <= i_dat_wdata;
      end
    end
  end

  // Endpoint 0 and pipes 1-3 / 5-7 give the seven pipes
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_max_in_pkt  <= '0;
      o_max_out_pkt <= '0;
    end else begin
      if (!idx_ok) begin
        o_max_in_pkt  <= '0;
        o_max_out_pkt <= '0;
      end else begin
        o_max_in_pkt  <= (idx_ep && in_h_q[idx][`USBF_INH_DBL]) ?
                         (psize[{split[idx], idx}] >> 1) : psize[{split[idx], idx}];
        o_max_out_pkt <= (idx_ep && (split[idx] ? out_h_q[idx][`USBF_OUTH_DBL]
                                                : in_h_q[idx][`USBF_INH_DBL])) ?
                         (psize[{1'b0, idx}] >> 1) : psize[{1'b0, idx}];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_function_address <= '0;
      o_power            <= `USBF_RST_POWER;
      o_ep_enable        <= `USBF_RST_EP_EN;
    end else begin
      o_function_address <= function_address_q;
      o_power            <= power_q;
      o_ep_enable        <= ep_en_q;
    end
  end

  // ****************************************
  // Transceiver, clock and VBUS
  // ****************************************
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      vbus_s1_q <= 1'b0;
      vbus_s2_q <= 1'b0;
      vbus_s3_q <= 1'b0;
    end else begin
      vbus_s1_q <= i_vbus;
      vbus_s2_q <= vbus_s1_q;
      vbus_s3_q <= vbus_s2_q;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_bus_power_level <= 1'b0;
      o_vbus_irq        <= 1'b0;
      o_sys_rst_req     <= 1'b0;
    end else begin
      o_bus_power_level <= vbus_s2_q;
      o_vbus_irq        <= (vbus_s2_q && !vbus_s3_q && i_vbus_rise_ie) ||
                           (!vbus_s2_q && vbus_s3_q && i_vbus_fall_ie);
      o_sys_rst_req     <= i_usb_rst_src_en && (vbus_s2_q != vbus_s3_q);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_xcvr_ctrl <= '0;
    end else if (i_xcvr_wr) begin
      o_xcvr_ctrl <= i_xcvr_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_xcvr_en    <= 1'b0;
      o_full_speed <= 1'b0;
      o_pullup_dp  <= 1'b0;
      o_pullup_dm  <= 1'b0;
    end else begin
      o_xcvr_en    <= o_xcvr_ctrl.xcvr_en;
      o_full_speed <= o_xcvr_ctrl.speed;
      o_pullup_dp  <= o_xcvr_ctrl.pullup_en && vbus_s2_q && o_xcvr_ctrl.speed;
      o_pullup_dm  <= o_xcvr_ctrl.pullup_en && vbus_s2_q && !o_xcvr_ctrl.speed;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_usb_clk_en  <= 1'b0;
      o_usb_clk_src <= '0;
    end else if (i_clk_sel_wr) begin
      o_usb_clk_en  <= i_clk_src_en;
      o_usb_clk_src <= i_clk_src;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_clock_recovery_control_trim_en <= 1'b0;
    end else begin
      o_clock_recovery_control_trim_en <= clock_recovery_control_q[`USBF_CLOCK_RECOVERY_CONTROL_EN] &&
                          (o_xcvr_ctrl.speed || clock_recovery_control_q[`USBF_CLOCK_RECOVERY_CONTROL_LOW]);
    end
  end
endmodule // usbf_top

// *** dv/usbf_top_sva.sv ***
module usbf_top_sva (
  input wire logic i_clk, i_rst_n, i_dat_rd, i_tx_req, i_vbus, i_clk_sel_wr, i_clk_src_en,
  input wire logic o_dat_rvalid, o_tx_valid, o_pullup_dp, o_pullup_dm, o_usb_clk_en,
  input wire logic o_bus_power_level, o_vbus_irq,
  input wire logic [7:0] o_dat_rdata,
  input wire usbf_pkg::usbf_xcvr_t o_xcvr_ctrl
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_rd_ans;
    ##1 o_dat_rvalid;
  endsequence
  a_rd_answer: assert property (i_dat_rd |-> s_rd_ans) else $error("no read answer");
  a_rd_idle: assert property (!o_dat_rvalid |-> o_dat_rdata == 8'h00)
    else $error("read data not idle");
  a_tx_cause: assert property (o_tx_valid |-> $past(i_tx_req)) else $error("stray tx");
  a_dp_speed: assert property (
    o_pullup_dp |-> $past(o_xcvr_ctrl.pullup_en & o_xcvr_ctrl.speed)) else $error("dp pull-up");
  a_pull_excl: assert property (!(o_pullup_dp && o_pullup_dm)) else $error("two pulls");
  a_vbus_level: assert property ($rose(o_bus_power_level) |-> $past(i_vbus, 3))
    else $error("bus level early");
  a_vbus_edge: assert property (o_vbus_irq |-> $changed(o_bus_power_level))
    else $error("irq without edge");
  a_clk_gate: assert property ($rose(o_usb_clk_en) |-> $past(i_clk_sel_wr & i_clk_src_en))
    else $error("clock ungated");
endmodule // usbf_top_sva

// *** dv/usbf_sie_model.sv ***
module usbf_sie_model (
  input  wire logic          i_clk,
  input  wire logic          i_ready,
  output logic               o_valid,
  output usbf_pkg::usbf_rx_t o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_valid = 1'b0;
    o_data  = '1;
  end
  // Hold the byte until taken, then show its inverse
  task automatic send(input logic [1:0] ep, input logic [7:0] b);
    @(negedge i_clk);
    o_valid = 1'b1;
    o_data  = {ep, b};
    while (i_ready !== 1'b1) @(negedge i_clk);
    @(negedge i_clk);
    o_valid = 1'b0;
    o_data  = ~o_data;
  endtask
endmodule // usbf_sie_model

// *** dv/tb_usbf_top.sv ***
module tb_usbf_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_rst_n, i_adr_wr, i_dat_wr, i_dat_rd, i_xcvr_wr, i_clk_sel_wr, i_clk_src_en;
  logic i_vbus, i_vbus_rise_ie, i_vbus_fall_ie, i_usb_rst_src_en, i_rx_valid, i_tx_req;
  logic o_dat_rvalid, o_xcvr_en, o_full_speed, o_pullup_dp, o_pullup_dm, o_usb_clk_en;
  logic o_clock_recovery_control_trim_en, o_bus_power_level, o_vbus_irq, o_sys_rst_req, o_rx_ready, o_tx_valid;
  logic [7:0] i_adr_wdata, i_dat_wdata, o_dat_rdata, o_power, o_ep_enable, o_tx_data;
  logic [2:0] i_clk_src, o_usb_clk_src;
  logic [1:0] i_tx_ep;
  logic [10:0] i_frame_num;
  logic [6:0] o_function_address;
  logic [9:0] o_max_in_pkt, o_max_out_pkt;
  usbf_pkg::usbf_xcvr_t i_xcvr_wdata, o_xcvr_ctrl;
  usbf_pkg::usbf_evt_t i_sie_evt;
  usbf_pkg::usbf_rx_t i_rx_data;
  int bad_count, checks_done, n_irq, n_rst;
  usbf_top u_usbf_top (.*);
  usbf_sie_model u_usbf_sie_model (.i_clk(i_clk), .i_ready(o_rx_ready), .o_valid(i_rx_valid),
    .o_data(i_rx_data));
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    n_irq += int'(o_vbus_irq === 1'b1);
    n_rst += int'(o_sys_rst_req === 1'b1);
  end
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk) {i_adr_wr, i_adr_wdata} = {1'b1, a};
    @(negedge i_clk) {i_adr_wr, i_dat_wr, i_dat_wdata} = {2'b01, d};
    @(negedge i_clk) i_dat_wr = 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(negedge i_clk) {i_adr_wr, i_adr_wdata} = {1'b1, a};
    @(negedge i_clk) {i_adr_wr, i_dat_rd} = 2'b01;
    @(negedge i_clk) i_dat_rd = 1'b0;
    chk({o_dat_rvalid, o_dat_rdata}, {1'b1, e});
  endtask
  task automatic xw(input logic [7:0] d);
    @(negedge i_clk) {i_xcvr_wr, i_xcvr_wdata} = {1'b1, d};
    @(negedge i_clk) i_xcvr_wr = 1'b0;
    @(negedge i_clk);
  endtask
  task automatic t_regs;
    rc(8'h01, 8'h10);
    rc(8'h09, 8'h0E);
    rc(8'h0B, 8'h06);
    wr(8'h03, 8'hFF);
    rc(8'h03, 8'h00);
    wr(8'h00, 8'h35);
    @(negedge i_clk) chk(o_function_address, 7'h35);
    chk(o_power, 8'h10);
    chk(o_ep_enable, 8'h0F);
    $display("regs done");
  endtask
  task automatic t_flags;
    @(negedge i_clk) i_sie_evt = {8'h05, 8'h0A, 8'h03};
    @(negedge i_clk) i_sie_evt = '0;
    rc(8'h02, 8'h05);
    rc(8'h02, 8'h00);
    rc(8'h04, 8'h0A);
    rc(8'h06, 8'h03);
    $display("flags done");
  endtask
  task automatic t_xcvr;
    xw(8'hF8);
    chk({o_xcvr_en, o_full_speed, o_pullup_dp, o_pullup_dm}, 4'hE);
    chk(o_xcvr_ctrl, 8'hF8);
    xw(8'hC0);
    chk({o_xcvr_en, o_full_speed, o_pullup_dp, o_pullup_dm}, 4'h9);
    {i_vbus_rise_ie, i_vbus_fall_ie, i_usb_rst_src_en, i_vbus} = 4'hE;
    repeat (5) @(negedge i_clk);
    chk({o_bus_power_level, o_pullup_dm}, 2'h0);
    i_vbus = 1'b1;
    repeat (5) @(negedge i_clk);
    chk({o_bus_power_level, o_pullup_dm, n_irq == 2, n_rst > 0}, 4'hF);
    chk(o_usb_clk_en, 1'b0);
    @(negedge i_clk) {i_clk_sel_wr, i_clk_src_en, i_clk_src} = 5'h1A;
    @(negedge i_clk) i_clk_sel_wr = 1'b0;
    @(negedge i_clk) chk({o_usb_clk_en, o_usb_clk_src}, 4'hA);
    wr(8'h0F, 8'h80);
    @(negedge i_clk) chk(o_clock_recovery_control_trim_en, 1'b0);
    wr(8'h0F, 8'hA0);
    @(negedge i_clk) chk(o_clock_recovery_control_trim_en, 1'b1);
    $display("xcvr done");
  endtask
  task automatic t_pkt;
    logic [7:0] ix [7] = '{8'h01, 8'h01, 8'h01, 8'h02, 8'h02, 8'h03, 8'h04};
    logic [7:0] hi [7] = '{8'h00, 8'h04, 8'h84, 8'h00, 8'h84, 8'h80, 8'h00};
    logic [9:0] ex [7] = '{10'h080, 10'h040, 10'h020, 10'h100, 10'h040, 10'h100, 10'h000};
    logic [9:0] eo [7] = '{10'h080, 10'h040, 10'h040, 10'h100, 10'h080, 10'h100, 10'h000};
    for (int k = 0; k < 7; k++) begin
      wr(8'h0E, ix[k]);
      wr(8'h12, hi[k]);
      repeat (2) @(negedge i_clk);
      chk(o_max_in_pkt, ex[k]);
      chk(o_max_out_pkt, eo[k]);
    end
    $display("pkt done");
  endtask
  task automatic t_fifo;
    chk(o_rx_ready, 1'b1);
    wr(8'h0E, 8'h00);
    for (int k = 0; k < 3; k++) u_usbf_sie_model.send(2'h0, 8'hA0 + 8'(k));
    repeat (4) @(negedge i_clk);
    for (int k = 0; k < 3; k++) rc(8'h20, 8'hA0 + 8'(k));
    rc(8'h20, 8'h00);
    wr(8'h20, 8'h5A);
    wr(8'h20, 8'hC3);
    for (int k = 0; k < 2; k++) begin
      @(negedge i_clk) i_tx_req = 1'b1;
      @(negedge i_clk) i_tx_req = 1'b0;
      chk({o_tx_valid, o_tx_data}, {1'b1, k ? 8'hC3 : 8'h5A});
    end
    wr(8'h0E, 8'h01);
    wr(8'h12, 8'h20);
    wr(8'h21, 8'h77);
    rc(8'h21, 8'h00);
    @(negedge i_clk) {i_tx_req, i_tx_ep} = 3'h5;
    @(negedge i_clk) i_tx_req = 1'b0;
    chk({o_tx_valid, o_tx_data}, 9'h177);
    $display("fifo done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    {i_rst_n, i_adr_wr, i_dat_wr, i_dat_rd, i_xcvr_wr, i_clk_sel_wr, i_clk_src_en} = '0;
    {i_tx_req, i_vbus_rise_ie, i_vbus_fall_ie, i_usb_rst_src_en, i_adr_wdata, i_dat_wdata} = '0;
    {i_clk_src, i_tx_ep, i_frame_num, i_xcvr_wdata, i_sie_evt} = '0;
    {i_vbus, bad_count, checks_done, n_irq, n_rst} = {1'b1, 128'h0};
    repeat (4) @(negedge i_clk);
    i_rst_n = 1'b1;
    t_regs;
    t_flags;
    t_xcvr;
    t_pkt;
    t_fifo;
    complete_run;
  end
  initial begin
    #20000;
    bad_count++;
    complete_run;
  end
endmodule // tb_usbf_top
bind usbf_top usbf_top_sva u_usbf_top_sva (.*);
